// ### hdl/load_operand_transform_unit.v
/*
 load operand transform unit: reversed halfword, doubleword, magnitude and
 negation loads into a sixteen slot accumulator file, with result flags and
 overflow / specification error events, reached over axi4-lite.
 assumes software places the operand word at the effective address in opnd0
 (and the odd word of a doubleword in opnd1) before starting an operation.
*/
// The address map and the AXI4-Lite register port were left to the implementer.
// How it works
// - reversed halfword: no index or even index right half, odd index next word's left half
// - after right-half load flags come from the slot's right half, one-hot
// - left load uses the reversed pick, writes left half, flags from left half
// - doubleword load writes the even slot and the odd slot after it
// - doubleword addressing shifts the index left one bit before adding
// - doubleword operands sit in even-odd pairs; both words are taken
// - any doubleword load with odd register field raises specification error
// - doubleword flags come from the full 64-bit pair value
// - magnitude word writes operand or its two's complement, then sets flags
// - magnitude of most negative word signals overflow and keeps that value
// - magnitude half picks by normal parity, writes left half, overflow at 8000
// - float magnitude clears the sign; flags only positive or zero; no event
// - pair magnitude clears the pair's sign bit, keeps the other 63 bits; flags only positive or zero
// - negated word writes two's complement; most negative overflows, kept
// - negated half picks by normal parity, writes left half; 8000 overflows
// - negated float flips only the sign bit, sets flags, raises no event
// - normal half pick: odd index right half, even or no index left half
// - right-half load keeps the slot's left half
`timescale 1ns/1ps
`default_nettype none
`include "load_unit_regs.vh"

module load_operand_transform_unit #(
	parameter ADDR_W = 8
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address and data
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// events and result code
	output reg overflow_evt_r,
	output reg spec_err_evt_r,
	output reg [2:0] result_flags_r
);

	localparam ST_IDLE = 2'd0;
	localparam ST_EXEC = 2'd1;
	localparam ST_FLAG = 2'd2;

	reg [1:0] state_r;
	reg [ADDR_W-1:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg aw_full_r;
	reg w_full_r;
	reg [7:0] op_r;
	reg [3:0] rf_r;
	reg idx_en_r;
	reg [31:0] index_r;
	reg [31:0] base_r;
	reg [31:0] opnd0_r;
	reg [31:0] opnd1_r;
	reg [2:0] flags_pend_r;
	reg ovf_r;
	reg spec_r;
	reg bad_op_r;
	reg [31:0] acc_r [0:15];

	// sign, nonzero to one-hot (neg, pos, zero)
	function [2:0] classify;
		input sgn;
		input nz;
		begin
			classify = {sgn & nz, ~sgn & nz, ~nz};
		end
	endfunction

	wire busy = (state_r != ST_IDLE);
	wire [31:0] k = idx_en_r ? index_r : `ZERO_WORD;
	wire do_write = aw_full_r && w_full_r && !s_axi_bvalid && !busy;
	wire [7:0] wa = awaddr_r[7:0];
	wire acc_hit_w = (wa[`ACC_SEL_HI:`ACC_SEL_LO] == 2'b01);
	wire [3:0] acc_wsel = wa[5:2];
	wire is_dw = (op_r == `OP_LOAD_DWORD) || (op_r == `OP_MAG_PAIR);
	wire is_nhalf = (op_r == `OP_MAG_HALF) || (op_r == `OP_NEG_HALF);
	wire is_rev = (op_r == `OP_LOAD_RIGHT) || (op_r == `OP_LOAD_LEFT);
	// partial strobes are refused: every field here is a whole aligned word
	wire wr_ok = (&wstrb_r) && (wa[1:0] == 2'b00) && (acc_hit_w || wa <= `REG_OPND1);
	reg [31:0] eaddr;
	always @* begin
		if (is_dw)
			eaddr = base_r + {k[30:0], 1'b0};
		else if (is_rev)
			eaddr = base_r + ((k + 32'h0000_0001) >> 1);
		else if (is_nhalf)
			eaddr = base_r + {1'b0, k[31:1]};
		else
			eaddr = base_r + k;
	end

	// reversed pick: even index right half; odd index was bumped to next word, left half
	wire [15:0] rev_half = k[0] ? opnd0_r[31:16] : opnd0_r[15:0];
	wire [15:0] nrm_half = k[0] ? opnd0_r[15:0] : opnd0_r[31:16];
	wire [31:0] neg_word = `ZERO_WORD - opnd0_r;
	wire [15:0] neg_half = 16'h0000 - nrm_half;
	wire [63:0] dw_in = {opnd0_r, opnd1_r};
	wire [31:0] cur = acc_r[rf_r];

	reg [1:0] wr_mode;
	reg [31:0] res_even;
	reg [31:0] res_odd;
	reg [2:0] flags_nxt;
	reg ovf_nxt;
	reg spec_nxt;
	reg bad_nxt;
	always @* begin
		wr_mode = `WR_WORD;
		res_even = cur;
		res_odd = opnd1_r;
		flags_nxt = flags_pend_r;
		ovf_nxt = 1'b0;
		spec_nxt = 1'b0;
		bad_nxt = 1'b0;
		case (op_r)
			`OP_LOAD_RIGHT: begin
				res_even = {cur[31:16], rev_half};
				flags_nxt = classify(rev_half[15], |rev_half);
			end
			`OP_LOAD_LEFT: begin
				res_even = {rev_half, cur[15:0]};
				flags_nxt = classify(rev_half[15], |rev_half);
			end
			`OP_LOAD_DWORD: begin
				wr_mode = `WR_PAIR;
				res_even = opnd0_r;
				res_odd = opnd1_r;
				flags_nxt = classify(dw_in[63], |dw_in);
			end
			`OP_MAG_WORD: begin
				res_even = opnd0_r[31] ? neg_word : opnd0_r;
				ovf_nxt = (opnd0_r == `MOST_NEG_WORD);
				flags_nxt = classify(res_even[31], |res_even);
			end
			`OP_MAG_HALF: begin
				res_even = {(nrm_half[15] ? neg_half : nrm_half), cur[15:0]};
				ovf_nxt = (nrm_half == `MOST_NEG_HALF);
				flags_nxt = classify(res_even[31], |res_even[31:16]);
			end
			`OP_MAG_FLOAT: begin
				res_even = {1'b0, opnd0_r[30:0]};
				flags_nxt = classify(1'b0, |opnd0_r[30:0]);
			end
			`OP_MAG_PAIR: begin
				wr_mode = `WR_PAIR;
				res_even = {1'b0, opnd0_r[30:0]};
				res_odd = opnd1_r;
				flags_nxt = classify(1'b0, |{opnd0_r[30:0], opnd1_r});
			end
			`OP_NEG_WORD: begin
				res_even = neg_word;
				ovf_nxt = (opnd0_r == `MOST_NEG_WORD);
				flags_nxt = classify(neg_word[31], |neg_word);
			end
			`OP_NEG_HALF: begin
				res_even = {neg_half, cur[15:0]};
				ovf_nxt = (nrm_half == `MOST_NEG_HALF);
				flags_nxt = classify(neg_half[15], |neg_half);
			end
			`OP_NEG_FLOAT: begin
				res_even = {~opnd0_r[31], opnd0_r[30:0]};
				flags_nxt = classify(~opnd0_r[31], |opnd0_r[30:0]);
			end
			default: begin
				wr_mode = `WR_NONE;
				bad_nxt = 1'b1;
			end
		endcase
		// odd pair register: no write, flags kept, specification error
		if (is_dw && rf_r[0]) begin
			wr_mode = `WR_NONE;
			spec_nxt = 1'b1;
			flags_nxt = flags_pend_r;
		end
	end

	// accumulator file, one slot per generate entry; execution has the port to itself
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_acc
			always @(posedge aclk) begin
				if (!aresetn)
					acc_r[gi] <= `ZERO_WORD;
				else if (state_r == ST_EXEC && wr_mode != `WR_NONE && rf_r == gi)
					acc_r[gi] <= res_even;
				else if (state_r == ST_EXEC && wr_mode == `WR_PAIR && (rf_r | 4'h1) == gi)
					acc_r[gi] <= res_odd;
				else if (do_write && wr_ok && acc_hit_w && acc_wsel == gi)
					acc_r[gi] <= wdata_r;
			end
		end
	endgenerate

	// sequencer and control registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_IDLE;
			op_r <= 8'h00;
			rf_r <= 4'h0;
			idx_en_r <= 1'b0;
			index_r <= `ZERO_WORD;
			base_r <= `ZERO_WORD;
			opnd0_r <= `ZERO_WORD;
			opnd1_r <= `ZERO_WORD;
			flags_pend_r <= `FLAGS_RESET;
			result_flags_r <= `FLAGS_RESET;
			ovf_r <= 1'b0;
			spec_r <= 1'b0;
			bad_op_r <= 1'b0;
			overflow_evt_r <= 1'b0;
			spec_err_evt_r <= 1'b0;
		end else begin
			overflow_evt_r <= 1'b0;
			spec_err_evt_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (do_write && wr_ok) begin
						if (wa == `REG_CTRL) begin
							op_r <= wdata_r[`CTRL_OP_HI:`CTRL_OP_LO];
							rf_r <= wdata_r[`CTRL_RF_HI:`CTRL_RF_LO];
							idx_en_r <= wdata_r[`CTRL_IDX_EN];
							if (wdata_r[`CTRL_START]) begin
								state_r <= ST_EXEC;
								ovf_r <= 1'b0;
								spec_r <= 1'b0;
								bad_op_r <= 1'b0;
							end
						end
						case (wa)
							`REG_INDEX: index_r <= wdata_r;
							`REG_BASE: base_r <= wdata_r;
							`REG_OPND0: opnd0_r <= wdata_r;
							`REG_OPND1: opnd1_r <= wdata_r;
							default: ;
						endcase
					end
				end
				ST_EXEC: begin
					flags_pend_r <= flags_nxt;
					ovf_r <= ovf_nxt;
					spec_r <= spec_nxt;
					bad_op_r <= bad_nxt;
					overflow_evt_r <= ovf_nxt;
					spec_err_evt_r <= spec_nxt;
					state_r <= ST_FLAG;
				end
				ST_FLAG: begin
					// flags follow the slot write by one cycle
					result_flags_r <= flags_pend_r;
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// axi write channels; a write waits while an operation runs
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awaddr_r <= {ADDR_W{1'b0}};
			wdata_r <= `ZERO_WORD;
			wstrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_r <= s_axi_awaddr;
				aw_full_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				w_full_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// axi read channel
	wire [7:0] ra = s_axi_araddr[7:0];
	reg [31:0] rd_val;
	reg rd_err;
	always @* begin
		rd_val = `ZERO_WORD;
		rd_err = 1'b0;
		if (ra[`ACC_SEL_HI:`ACC_SEL_LO] == 2'b01)
			rd_val = acc_r[ra[5:2]];
		else
			case (ra)
				`REG_CTRL: rd_val = {19'h0_0000, idx_en_r, rf_r, op_r};
				`REG_INDEX: rd_val = index_r;
				`REG_BASE: rd_val = base_r;
				`REG_OPND0: rd_val = opnd0_r;
				`REG_OPND1: rd_val = opnd1_r;
				`REG_STATUS: rd_val = {25'h000_0000, bad_op_r, busy, spec_r, ovf_r, result_flags_r};
				`REG_EADDR: rd_val = eaddr;
				default: rd_err = 1'b1;
			endcase
		if (ra[1:0] != 2'b00)
			rd_err = 1'b1;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `ZERO_WORD;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_err ? `ZERO_WORD : rd_val;
				s_axi_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // load_operand_transform_unit

`default_nettype wire

// ### hdl/load_unit_regs.vh
/*
 constants for the load operand transform unit: opcodes, register offsets,
 field positions, reset values, response codes and write modes.
 assumes it is included once by bare name from the design file.
*/
`ifndef LOAD_UNIT_REGS_VH
`define LOAD_UNIT_REGS_VH

// opcodes
`define OP_LOAD_RIGHT 8'h1D
`define OP_LOAD_LEFT 8'h19
`define OP_LOAD_DWORD 8'h17
`define OP_MAG_WORD 8'h3C
`define OP_MAG_HALF 8'h3D
`define OP_MAG_FLOAT 8'h3E
`define OP_MAG_PAIR 8'h3F
`define OP_NEG_WORD 8'h30
`define OP_NEG_HALF 8'h31
`define OP_NEG_FLOAT 8'h32

// register byte offsets
`define REG_CTRL 8'h00
`define REG_INDEX 8'h04
`define REG_BASE 8'h08
`define REG_OPND0 8'h0C
`define REG_OPND1 8'h10
`define REG_STATUS 8'h14
`define REG_EADDR 8'h18
`define REG_ACC_BASE 8'h40
`define ACC_SEL_HI 7
`define ACC_SEL_LO 6

// control fields
`define CTRL_OP_HI 7
`define CTRL_OP_LO 0
`define CTRL_RF_HI 11
`define CTRL_RF_LO 8
`define CTRL_IDX_EN 12
`define CTRL_START 31

// constants
`define MOST_NEG_WORD 32'h8000_0000
`define MOST_NEG_HALF 16'h8000
`define ZERO_WORD 32'h0000_0000
`define FLAGS_RESET 3'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// write modes
`define WR_NONE 2'h0
`define WR_WORD 2'h1
`define WR_PAIR 2'h2

`endif

// ### tb/load_unit_props.sv
/* checker: bus answers, event pulses and result flag timing of the load unit.
 assumes it is bound to the top module's ports. */
`timescale 1ns/1ps
`default_nettype none
module load_unit_checker (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// results
	input wire logic overflow_evt_r,
	input wire logic spec_err_evt_r,
	input wire logic [2:0] result_flags_r
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// busy can delay the answer by up to two cycles
	a_write_answer: assert property (s_wr_taken |-> ##[1:4] s_axi_bvalid)
		else $error("write answer late");
	a_busy_ready: assert property (s_wr_taken |=> !s_axi_awready && !s_axi_wready)
		else $error("write readies stayed high");
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	a_flags_one_hot: assert property ($onehot(result_flags_r))
		else $error("flags not one-hot");
	a_flags_late: assert property ($changed(result_flags_r) |-> $past(s_axi_bvalid, 2))
		else $error("flags moved out of step");
	a_ovf_pulse: assert property (overflow_evt_r |-> $past(s_axi_bvalid, 1) ##1 !overflow_evt_r)
		else $error("overflow pulse wrong");
	a_spec_pulse: assert property (spec_err_evt_r |-> $past(s_axi_bvalid, 1) ##1 $stable(result_flags_r))
		else $error("spec error pulse wrong");
	a_events_apart: assert property (!(overflow_evt_r && spec_err_evt_r))
		else $error("both events at once");
endmodule // load_unit_checker
bind load_operand_transform_unit load_unit_checker load_unit_checker_inst (.*);
`default_nettype wire

// ### tb/operand_store.sv
/* partner model: central memory words offered to the operand registers.
 assumes the bench fills mem and drives the effective word address. */
`timescale 1ns/1ps
`default_nettype none
module operand_store (
	// effective word address
	input wire logic [7:0] ea,
	// addressed word and odd word of its pair
	output logic [31:0] word_at,
	output logic [31:0] word_odd
);
	logic [31:0] mem [0:255];
	// unfilled words carry a pattern, so a stray fetch never reads as zero
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 32'hC3C3_0000 ^ i;
	end
	assign word_at = mem[ea];
	assign word_odd = mem[{ea[7:1], 1'b1}];
endmodule // operand_store
`default_nettype wire

// ### tb/testbench.sv
/* bench: drives the load unit over axi4-lite, checks slots, flags and status.
 assumes operand_store holds the words at each effective address. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	localparam logic [31:0] IV = 32'hA5A5_5A5A;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ea = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, word_at, word_odd, rv;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic overflow_evt_r, spec_err_evt_r;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [2:0] result_flags_r;
	int error_cnt = 0, comparisons = 0;
	int ovf_seen = 0, spec_seen = 0;
	always #4 aclk = ~aclk;
	// event pulses last one cycle, so they are counted here rather than polled
	always @(posedge aclk) begin
		ovf_seen <= ovf_seen + int'(overflow_evt_r === 1'b1);
		spec_seen <= spec_seen + int'(spec_err_evt_r === 1'b1);
	end
	load_operand_transform_unit load_operand_transform_unit_inst (.*);
	operand_store operand_store_inst (.*);
	task close_out;
		$display("mismatches %0d, comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, r)
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		rs = s_axi_rresp;
	endtask
	task c(input logic [7:0] op, input logic [3:0] rf, input logic [7:0] k,
		input logic [31:0] w0, w1, e0, e1, input logic [4:0] st);
		logic [7:0] e;
		logic [7:0] sa;
		int n_ovf, n_spec;
		sa = 8'h40 + {2'b00, rf, 2'b00};
		case (op)
			8'h1D, 8'h19: e = 8'h10 + ((k + 8'h01) >> 1);
			8'h17, 8'h3F: e = 8'h10 + (k << 1);
			8'h3D, 8'h31: e = 8'h10 + (k >> 1);
			default: e = 8'h10 + k;
		endcase
		// odd word first: a single-word address may itself be odd
		operand_store_inst.mem[e | 8'h01] = w1;
		operand_store_inst.mem[e] = w0;
		ea = e;
		wr(sa, IV, 2'h0);
		wr(sa | 8'h04, IV, 2'h0);
		wr(8'h04, {24'h00_0000, k}, 2'h0);
		wr(8'h08, 32'h0000_0010, 2'h0);
		wr(8'h0C, word_at, 2'h0);
		wr(8'h10, word_odd, 2'h0);
		n_ovf = ovf_seen;
		n_spec = spec_seen;
		wr(8'h00, {1'b1, 18'h0_0000, k != 8'h00, rf, op}, 2'h0);
		repeat (4) begin
			rd(8'h14, rv);
			if (rv[5] === 1'b0)
				break;
		end
		`CHK(rv[6:0], {2'b00, st})
		`CHK(result_flags_r, st[2:0])
		`CHK(ovf_seen - n_ovf, int'(st[3]))
		`CHK(spec_seen - n_spec, int'(st[4]))
		rd(8'h18, rv);
		`CHK(rv, {24'h00_0000, e})
		rd(sa, rv);
		`CHK(rv, e0)
		rd(sa | 8'h04, rv);
		`CHK(rv, e1)
	endtask
	task t_regs;
		rd(8'h14, rv);
		`CHK(rv, 32'h0000_0001)
		rd(8'h20, rv);
		`CHK({rs, rv}, {2'h2, 32'h0})
		wr(8'h14, 32'h0, 2'h2);
		s_axi_wstrb <= 4'h3;
		wr(8'h40, 32'h0000_0001, 2'h2);
		s_axi_wstrb <= 4'hF;
		wr(8'h41, 32'h0000_0001, 2'h2);
		wr(8'h00, 32'h8000_0000, 2'h0);
		rd(8'h14, rv);
		`CHK(rv, 32'h0000_0041)
		rd(8'h40, rv);
		`CHK(rv, 32'h0)
	endtask
	task t_reversed;
		c(8'h1D, 2, 2, 32'h1111_0005, 32'h0, 32'hA5A5_0005, IV, 5'h02);
		c(8'h1D, 2, 3, 32'h0000_1234, 32'h0, 32'hA5A5_0000, IV, 5'h01);
		c(8'h19, 2, 1, 32'h7FFF_0000, 32'h0, 32'h7FFF_5A5A, IV, 5'h02);
		c(8'h1D, 2, 0, 32'h0000_8001, 32'h0, 32'hA5A5_8001, IV, 5'h04);
	endtask
	task t_pairs;
		c(8'h17, 5, 0, 32'h1, 32'h1, IV, IV, 5'h14);
		c(8'h17, 4, 3, 32'h8000_0000, 32'h1, 32'h8000_0000, 32'h1, 5'h04);
		c(8'h17, 4, 0, 32'h0, 32'h8000_0000, 32'h0, 32'h8000_0000, 5'h02);
		c(8'h3F, 6, 1, 32'h1234_5678, 32'h0, 32'h1234_5678, 32'h0, 5'h02);
		c(8'h3F, 6, 0, 32'h8000_0000, 32'h0, 32'h0, 32'h0, 5'h01);
		c(8'h3F, 7, 0, 32'h1, 32'h1, IV, IV, 5'h11);
	endtask
	task t_magnitude;
		c(8'h3C, 2, 0, 32'hFFFF_FFFB, 32'h0, 32'h0000_0005, IV, 5'h02);
		c(8'h3C, 2, 0, 32'h8000_0000, 32'h0, 32'h8000_0000, IV, 5'h0C);
		c(8'h3D, 2, 1, 32'h1234_FFFE, 32'h0, 32'h0002_5A5A, IV, 5'h02);
		c(8'h3D, 2, 2, 32'h8000_1111, 32'h0, 32'h8000_5A5A, IV, 5'h0C);
		c(8'h3E, 2, 0, 32'hC000_0001, 32'h0, 32'h4000_0001, IV, 5'h02);
	endtask
	task t_negate;
		c(8'h30, 2, 0, 32'h0000_0001, 32'h0, 32'hFFFF_FFFF, IV, 5'h04);
		c(8'h31, 2, 0, 32'h0003_7777, 32'h0, 32'hFFFD_5A5A, IV, 5'h04);
		c(8'h32, 2, 0, 32'h4000_0000, 32'h0, 32'hC000_0000, IV, 5'h04);
		c(8'h30, 2, 0, 32'h8000_0000, 32'h0, 32'h8000_0000, IV, 5'h0C);
		c(8'h31, 2, 1, 32'h1111_8000, 32'h0, 32'h8000_5A5A, IV, 5'h0C);
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_reversed();
		t_pairs();
		t_magnitude();
		t_negate();
		close_out();
	end
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
endmodule // testbench
`default_nettype wire
